// ==== logic/wdnmi_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the watchdog.
// Assumes an APB slave with 32-bit data and word-aligned byte addresses.
`ifndef WDNMI_REGS_SVH
`define WDNMI_REGS_SVH

`define WDNMI_COUNT_OFS      12'h000
`define WDNMI_CTRL_OFS       12'h004
`define WDNMI_FRZ_SET_OFS    12'h008
`define WDNMI_FRZ_CLR_OFS    12'h00c
`define WDNMI_STATUS_OFS     12'h010
`define WDNMI_SYSCTRL_OFS    12'h014

`define WDNMI_COUNT_W        9
`define WDNMI_GUARD_LSB      9
`define WDNMI_GUARD_MSB      15
`define WDNMI_CTRL_DIRRST    0
`define WDNMI_FREEZE_BIT     0
`define WDNMI_REMAP_W        2

`define WDNMI_COUNT_RST      9'h0ff
`define WDNMI_RESET_LEVEL    9'h1f0
`define WDNMI_REMAP_RST      2'h0

`define WDNMI_CLK_PERIOD_PS  5000
`define WDNMI_TICK_PERIOD_US 10240
`define WDNMI_TICK_CYCLES    ((`WDNMI_TICK_PERIOD_US * 1000 * 1000) / `WDNMI_CLK_PERIOD_PS)

`endif

// ==== logic/wdnmi_pkg.sv ====
// Types shared by the watchdog design.
// Assumes the constants of wdnmi_regs.svh for field widths.
package wdnmi_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wdnmi_apb_req_t;

  typedef struct packed {
    logic        prdata_valid;
    logic [31:0] prdata;
  } wdnmi_apb_rsp_t;

  typedef enum logic [1:0] {
    WDNMI_RUN,
    WDNMI_NMI_SENT,
    WDNMI_EXPIRED
  } wdnmi_state_t;

endpackage

// ==== logic/wdnmi_top.sv ====
// Watchdog with non-maskable interrupt and system reset request, APB register slave.
// Assumes one 200 MHz clock pclk, reset presetn, and that the reset controller
// answers sys_reset_req by pulsing presetn low for the whole system.
// Also assumes hw_resetn comes from the pin and power-on resets only, and that
// debug_halted is already synchronous to pclk.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "wdnmi_regs.svh"

module wdnmi_top #(
  parameter int unsigned TICK_CYCLES = `WDNMI_TICK_CYCLES
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    hw_resetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    debug_halted,
  output logic                         nmi_req,
  output logic                         sys_reset_req,
  output logic                         debug_freeze,
  output logic      [`WDNMI_REMAP_W-1:0] boot_remap_select
);

  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  // Bus request carrier and watchdog state.
  wdnmi_pkg::wdnmi_apb_req_t req;
  wdnmi_pkg::wdnmi_state_t   state_q;
  wdnmi_pkg::wdnmi_state_t   state_d;

  // Registers of the block, with the tick strobe and the next count.
  logic [TW-1:0]               tick_cnt_q;
  logic                        tick;
  logic [`WDNMI_COUNT_W-1:0]   count_q;
  logic [`WDNMI_COUNT_W-1:0]   count_d;
  logic                        direct_rst_q;
  logic                        freeze_q;
  logic                        nmi_q;
  logic                        rst_req_q;
  logic [`WDNMI_REMAP_W-1:0]   remap_q;
  logic [31:0]                 rdata_q;

  // Bus and counter decode.
  logic                        wr_acc;
  logic                        rd_acc;
  logic                        sel_count;
  logic                        sel_ctrl;
  logic                        sel_fset;
  logic                        sel_fclr;
  logic                        sel_stat;
  logic                        sel_sys;
  logic                        mapped;
  logic                        guard_ok;
  logic                        count_wr;
  logic                        frozen;
  logic                        step;
  logic                        at_zero;
  logic                        at_or_below_zero;
  logic                        at_reset_level;
  logic [31:0]                 rdata_d;

  // Write strobes, expiry decode and next values.
  logic [TW-1:0]               tick_cnt_d;
  logic                        wr_ctrl;
  logic                        wr_fset;
  logic                        wr_fclr;
  logic                        wr_sys;
  logic                        set_direct;
  logic                        set_freeze;
  logic                        clr_freeze;
  logic                        nmi_mode;
  logic                        nmi_arm;
  logic                        nmi_expire;
  logic                        direct_expire;
  logic                        handler_lift;
  logic                        enter_nmi;
  logic                        expire_next;
  logic [2:0]                  status_bits;

  // Signed view of the 9-bit count: bit 8 is the sign.
  function automatic logic le_signed(input logic [`WDNMI_COUNT_W-1:0] a,
                                     input logic [`WDNMI_COUNT_W-1:0] b);
    le_signed = $signed(a) <= $signed(b);
  endfunction

  // One address comparator shared by every register select.
  function automatic logic addr_hit(input logic [11:0] addr,
                                    input logic [11:0] ofs);
    addr_hit = addr == ofs;
  endfunction

  assign req.psel    = psel;
  assign req.penable = penable;
  assign req.pwrite  = pwrite;
  assign req.paddr   = paddr;
  assign req.pwdata  = pwdata;

  // Zero wait states: every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign wr_acc  = req.psel && req.penable && req.pwrite;
  assign rd_acc  = req.psel && !req.penable && !req.pwrite;

  // Register map, one aligned word each:
  //   count       signed count in bits 8 to 0, the guard field above must be zero;
  //   control     direct-reset select in bit 0, which can only be set;
  //   freeze set  a one in bit 0 holds the counter in NMI mode only, reads back the freeze;
  //   freeze clr  a one in bit 0 releases it, reads back the freeze;
  //   status      read only: reset request, interrupt pulse, frozen;
  //   sysctrl     boot remap select, which a watchdog reset keeps.
  // Unmapped words answer with an error and read as zero.
  assign sel_count = addr_hit(req.paddr, `WDNMI_COUNT_OFS);
  assign sel_ctrl  = addr_hit(req.paddr, `WDNMI_CTRL_OFS);
  assign sel_fset  = addr_hit(req.paddr, `WDNMI_FRZ_SET_OFS);
  assign sel_fclr  = addr_hit(req.paddr, `WDNMI_FRZ_CLR_OFS);
  assign sel_stat  = addr_hit(req.paddr, `WDNMI_STATUS_OFS);
  assign sel_sys   = addr_hit(req.paddr, `WDNMI_SYSCTRL_OFS);
  assign mapped    = sel_count | sel_ctrl | sel_fset | sel_fclr | sel_stat | sel_sys;
  assign pslverr   = req.psel && req.penable && !mapped;

  // A runaway program writing all ones never gets through the guard bits.
  assign guard_ok = req.pwdata[`WDNMI_GUARD_MSB:`WDNMI_GUARD_LSB] == 7'h00;
  assign count_wr = wr_acc && sel_count && guard_ok;

  // Write strobes, one per register; each lands at the access edge only.
  assign wr_ctrl = wr_acc && sel_ctrl;
  assign wr_fset = wr_acc && sel_fset;
  assign wr_fclr = wr_acc && sel_fclr;
  assign wr_sys  = wr_acc && sel_sys;

  // The select bit can only be raised; writing zero to it changes nothing.
  assign set_direct = wr_ctrl && req.pwdata[`WDNMI_CTRL_DIRRST];
  // With direct reset selected a software freeze is refused outright.
  assign set_freeze = wr_fset && req.pwdata[`WDNMI_FREEZE_BIT] && !direct_rst_q;
  assign clr_freeze = wr_fclr && req.pwdata[`WDNMI_FREEZE_BIT];

  // Debug halt freezes regardless of software; software freeze only in NMI mode.
  assign frozen = debug_halted || (freeze_q && !direct_rst_q);
  assign debug_freeze = debug_halted;

  assign tick = tick_cnt_q == TW'(TICK_CYCLES - 1);
  assign step = tick && !frozen;

  assign at_zero          = count_q == 9'h000;
  assign at_or_below_zero = le_signed(count_q, 9'h000);
  assign at_reset_level   = le_signed(count_q, `WDNMI_RESET_LEVEL);

  // Expiry conditions per mode; direct mode skips the interrupt stage.
  assign nmi_mode      = !direct_rst_q;
  assign nmi_arm       = nmi_mode && at_zero;
  assign nmi_expire    = nmi_mode && at_reset_level;
  assign direct_expire = direct_rst_q && at_or_below_zero;
  // A handler rewrite above zero leaves the interrupt stage and re-arms it.
  assign handler_lift  = !at_or_below_zero;

  // The interrupt fires on entry into its stage, never while staying there.
  assign enter_nmi   = state_q == wdnmi_pkg::WDNMI_RUN && state_d == wdnmi_pkg::WDNMI_NMI_SENT;
  assign expire_next = state_d == wdnmi_pkg::WDNMI_EXPIRED;
  assign status_bits = {rst_req_q, nmi_q, frozen};
  // The prescaler wraps by itself; the tick is its last count.
  assign tick_cnt_d  = tick ? '0 : tick_cnt_q + TW'(1);

  // A software write beats a tick in the same cycle, so a handler that writes
  // just as the tick lands never loses its value. The count holds at the
  // reset level instead of wrapping back to a positive value.

  always_comb
  begin
    count_d = count_q;
    if (count_wr)
      count_d = req.pwdata[`WDNMI_COUNT_W-1:0];
    else if (step && !at_reset_level)
      count_d = count_q - 9'h001;
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      wdnmi_pkg::WDNMI_RUN:
      begin
        if (direct_expire)
          state_d = wdnmi_pkg::WDNMI_EXPIRED;
        else if (nmi_expire)
          state_d = wdnmi_pkg::WDNMI_EXPIRED;
        else if (nmi_arm)
          state_d = wdnmi_pkg::WDNMI_NMI_SENT;
      end
      wdnmi_pkg::WDNMI_NMI_SENT:
      begin
        // A handler rewrite lifts the count and re-arms the interrupt stage.
        if (nmi_expire || direct_expire)
          state_d = wdnmi_pkg::WDNMI_EXPIRED;
        else if (handler_lift)
          state_d = wdnmi_pkg::WDNMI_RUN;
      end
      wdnmi_pkg::WDNMI_EXPIRED:
        state_d = wdnmi_pkg::WDNMI_EXPIRED;
      default:
        state_d = wdnmi_pkg::WDNMI_RUN;
    endcase
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (sel_count)
      rdata_d[`WDNMI_COUNT_W-1:0] = count_q;
    else if (sel_ctrl)
      rdata_d[`WDNMI_CTRL_DIRRST] = direct_rst_q;
    else if (sel_fset || sel_fclr)
      rdata_d[`WDNMI_FREEZE_BIT] = freeze_q;
    else if (sel_stat)
      rdata_d[2:0] = status_bits;
    else if (sel_sys)
      rdata_d[`WDNMI_REMAP_W-1:0] = remap_q;
  end

  // The reset controller turns sys_reset_req into presetn, which reloads 255.
  // Each register sits in a short process of its own so that its reset and
  // its update can be read side by side.

  // The prescaler runs on while the counter is frozen; a release then steps
  // on the regular tick grid instead of restarting a fresh period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  // The count is the only state that a handler rewrite touches directly.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= `WDNMI_COUNT_RST;
    else
      count_q <= count_d;
  end

  // Once expired the state stays put; only the system reset it asks for leaves it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= wdnmi_pkg::WDNMI_RUN;
    else
      state_q <= state_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      direct_rst_q <= 1'b0;
    else if (set_direct)
      direct_rst_q <= 1'b1;
  end

  // Set and clear sit at different addresses, so they never meet in one cycle.
  // A freeze set before direct reset was selected stays, but no longer holds.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      freeze_q <= 1'b0;
    else if (set_freeze)
      freeze_q <= 1'b1;
    else if (clr_freeze)
      freeze_q <= 1'b0;
  end

  // A registered pulse keeps the interrupt line free of decode glitches.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_q <= 1'b0;
    else
      nmi_q <= enter_nmi;
  end

  // The request stands as a level until presetn drops, so a slow reset
  // controller cannot miss it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_req_q <= 1'b0;
    else
      rst_req_q <= expire_next;
  end

  // Read data is captured in the setup cycle and stands through the access,
  // which lets pready stay high without a wait state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 32'h0000_0000;
    else if (rd_acc)
      rdata_q <= rdata_d;
  end

  // Remap lives on the hardware reset only, so a watchdog reset leaves it alone.
  always_ff @(posedge pclk or negedge hw_resetn)
  begin
    if (!hw_resetn)
      remap_q <= `WDNMI_REMAP_RST;
    else if (wr_sys)
      remap_q <= req.pwdata[`WDNMI_REMAP_W-1:0];
  end

  // The system control word carries only the remap field; the debug-enable bit
  // has no address here, so software has no path to it.
  assign boot_remap_select = remap_q;
  assign prdata            = rdata_q;
  assign nmi_req           = nmi_q;
  assign sys_reset_req     = rst_req_q;

endmodule // wdnmi_top

// ==== bench/wdnmi_asserts.sv ====
// Concurrent checks on the ports of the watchdog top.
// Assumes a bind to wdnmi_top with TICK_CYCLES handed on.
`timescale 1ns/100ps
`include "wdnmi_regs.svh"
module wdnmi_asserts #(
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        hw_resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        debug_halted,
  input wire logic        nmi_req,
  input wire logic        sys_reset_req,
  input wire logic        debug_freeze,
  input wire logic [1:0]  boot_remap_select
);
  // Sixteen ticks from zero to minus sixteen, plus eight cycles of margin.
  localparam int RW = 16 * TICK_CYCLES + 8;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rmw = acc && pwrite && (paddr == `WDNMI_SYSCTRL_OFS);
  sequence s_nmi; $rose(nmi_req); endsequence
  sequence s_out; sys_reset_req || psel || debug_halted; endsequence
  AST_FRZ_COPY: assert property (debug_freeze == debug_halted)
    else $error("debug freeze does not follow halt");
  AST_NMI_PULSE: assert property (nmi_req |=> !nmi_req)
    else $error("interrupt request longer than one cycle");
  AST_RST_HOLD: assert property (sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped before system reset");
  AST_NMI_NO_RST: assert property (nmi_req |-> !sys_reset_req)
    else $error("interrupt raised after reset stage");
  AST_HALT_NO_EVT: assert property ((debug_halted && !psel)[*4] |->
    !$rose(nmi_req) && !$rose(sys_reset_req))
    else $error("counter advanced while halted");
  AST_REMAP_KEEP: assert property ((hw_resetn && !rmw) |=>
    (!hw_resetn || $stable(boot_remap_select)))
    else $error("boot remap changed without write");
  AST_NMI_TO_RST: assert property (s_nmi |-> ##[1:RW] s_out)
    else $error("no reset after unanswered interrupt");
  AST_UNMAP: assert property ((acc && paddr > `WDNMI_SYSCTRL_OFS) |-> pslverr)
    else $error("unmapped access without error");
endmodule // wdnmi_asserts

// ==== bench/wdnmi_top_tb.sv ====
// Self-checking bench of the watchdog top, driving APB and debug halt.
// Assumes TICK_CYCLES of 8; after each sys_reset_req the bench pulses presetn low itself in the sysrst task.
`timescale 1ns/100ps
`include "wdnmi_regs.svh"
module wdnmi_top_tb;
  logic        pclk         = 1'b0;
  logic        presetn      = 1'b0;
  logic        hw_resetn    = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic        debug_halted = 1'b0;
  logic [11:0] paddr        = 12'h000;
  logic [31:0] pwdata       = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, nmi_req, sys_reset_req, debug_freeze, err;
  logic [1:0]  boot_remap_select;
  int          fail_count   = 0;
  int          comparisons  = 0;
  always #2.5 pclk = ~pclk;
  wdnmi_top #(.TICK_CYCLES(8)) u_wdnmi_top (.pclk(pclk), .presetn(presetn),
    .hw_resetn(hw_resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halted(debug_halted), .nmi_req(nmi_req), .sys_reset_req(sys_reset_req),
    .debug_freeze(debug_freeze), .boot_remap_select(boot_remap_select));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok)
    begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Called on a rising edge; leaves one idle cycle so psel is never assigned twice at once.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20)
    begin
      chk(1'b0, "no ready");
      final_report();
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [8:0] e, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd[8:0] === e, msg);
  endtask
  // Outputs are looked at on the falling edge, where they have settled.
  task automatic wait_for(input bit rst, input int lim);
    int n;
    n = 0;
    while ((rst ? sys_reset_req : nmi_req) !== 1'b1 && n < lim)
    begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    if (n >= lim)
    begin
      chk(1'b0, "event missing");
      final_report();
    end
  endtask
  task automatic sysrst();
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
  endtask
  task automatic t_reset();
    rdchk(`WDNMI_COUNT_OFS, 9'h0ff, "count reset");
    rdchk(`WDNMI_CTRL_OFS, 9'h000, "ctrl reset");
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_freeze();
    apb(1'b1, `WDNMI_FRZ_SET_OFS, 32'h0000_0001);
    apb(1'b1, `WDNMI_COUNT_OFS, 32'h0000_000a);
    apb(1'b1, `WDNMI_COUNT_OFS, 32'h0000_0205);
    cyc(20);
    rdchk(`WDNMI_COUNT_OFS, 9'h00a, "guarded or frozen count");
    apb(1'b1, `WDNMI_FRZ_CLR_OFS, 32'h0000_0001);
    cyc(20);
    apb(1'b0, `WDNMI_COUNT_OFS, 32'h0000_0000);
    chk(rd[8:0] === 9'h008 || rd[8:0] === 9'h007, "count rate");
    $display("test freeze done");
  endtask
  task automatic t_debug();
    logic [8:0] held;
    debug_halted <= 1'b1;
    cyc(1);
    chk(debug_freeze === 1'b1, "debug freeze");
    apb(1'b0, `WDNMI_COUNT_OFS, 32'h0000_0000);
    held = rd[8:0];
    cyc(40);
    rdchk(`WDNMI_COUNT_OFS, held, "halted count");
    debug_halted <= 1'b0;
    cyc(1);
    $display("test debug done");
  endtask
  task automatic t_nmi();
    apb(1'b1, `WDNMI_SYSCTRL_OFS, 32'h0000_0002);
    apb(1'b1, `WDNMI_COUNT_OFS, 32'h0000_0002);
    wait_for(1'b0, 40);
    cyc(10);
    apb(1'b0, `WDNMI_COUNT_OFS, 32'h0000_0000);
    chk(rd[8:0] === 9'h1ff || rd[8:0] === 9'h1fe, "negative count");
    apb(1'b1, `WDNMI_COUNT_OFS, 32'h0000_0010);
    cyc(100);
    chk(sys_reset_req === 1'b0, "reset despite rewrite");
    wait_for(1'b1, 400);
    rdchk(`WDNMI_COUNT_OFS, 9'h1f0, "final count");
    sysrst();
    rdchk(`WDNMI_COUNT_OFS, 9'h0ff, "count after watchdog reset");
    chk(boot_remap_select === 2'h2, "remap kept");
    $display("test nmi done");
  endtask
  task automatic t_direct();
    apb(1'b1, `WDNMI_CTRL_OFS, 32'h0000_0001);
    apb(1'b1, `WDNMI_CTRL_OFS, 32'h0000_0000);
    rdchk(`WDNMI_CTRL_OFS, 9'h001, "set only");
    apb(1'b1, `WDNMI_FRZ_SET_OFS, 32'h0000_0001);
    rdchk(`WDNMI_FRZ_SET_OFS, 9'h000, "freeze refused");
    apb(1'b1, `WDNMI_COUNT_OFS, 32'h0000_0001);
    wait_for(1'b1, 30);
    sysrst();
    rdchk(`WDNMI_CTRL_OFS, 9'h000, "cleared by reset");
    $display("test direct done");
  endtask
  initial
  begin
    cyc(5);
    presetn   <= 1'b1;
    hw_resetn <= 1'b1;
    cyc(1);
    t_reset();
    t_freeze();
    t_debug();
    t_nmi();
    t_direct();
    final_report();
  end
endmodule // wdnmi_top_tb
bind wdnmi_top wdnmi_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_wdnmi_asserts (.pclk(pclk),
  .presetn(presetn), .hw_resetn(hw_resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pslverr(pslverr), .debug_halted(debug_halted), .nmi_req(nmi_req),
  .sys_reset_req(sys_reset_req), .debug_freeze(debug_freeze),
  .boot_remap_select(boot_remap_select));
